// file: core/tlic_ctrl.sv
// Function
// R1 - A third top level exists; only the supply request sits there.
// R2 - A supply request pre-empts any other service routine.
// R3 - Enable bit 7 gates all sources; otherwise each follows its own enable.
// R4 - Enable bits 6..0: thermal, timer 2, uart, timer 1, ext 1, timer 0, ext 0.
// R5 - Level bits 7..0: metering, thermal, timer 2, uart, timer 1, ext 1, timer 0, ext 0.
// R6 - Extended register bit 6 clock level, bit 4 serial bus level.
// R7 - Extended bits 3..0 enable metering, clock interval, supply, serial bus.
// R8 - Extended bits 7 and 5 are reserved; register resets to A0.
// R9 - Enable and level registers are bit-addressable and reset to zero.
// R10 - Simultaneous requests of one level are taken in fixed polling order.
// R11 - Order: supply, clock, metering, watchdog, thermal, ext0, t0, ext1, t1, sbus, uart, t2.
// R12 - The supply source holds polling slot 0.
// R13 - Watchdog control sits at C0, bit-addressable, resets to 10.
// R14 - High pre-empts low; high is taken first when both arrive.
// R15 - A routine is never pre-empted at its own level.
// R16 - Acceptance pushes the counter and loads the source vector.
// R17 - Return restores the in-service state of the previous level.
module tlic_ctrl import tlic_pkg::*; (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register or bit address
  input wire logic [7:0] reg_wdata, // Write data, bit 0 for bit writes
  input wire logic reg_wr, // Byte write strobe
  input wire logic reg_rd, // Byte read strobe
  input wire logic bit_wr, // Bit write strobe
  input wire logic bit_rd, // Bit read strobe
  output logic [7:0] reg_rdata_q, // Read data, one cycle after the strobe
  input wire logic [TLIC_NSRC-1:0] src_req, // Pending requests in polling order
  input wire logic core_ret, // Core finished a service routine
  output tlic_take_t take_q, // Accepted interrupt, one-cycle pulse
  output logic [2:0] in_service_q, // Levels currently in service
  output logic [7:0] wdog_ctrl_q // Watchdog control register
);

  logic [7:0] enable_q, enable_d;
  logic [7:0] ext_q, ext_d;
  logic [7:0] level_sel_q, level_sel_d;
  logic [7:0] wdog_d;
  logic [7:0] rdata_d;
  tlic_take_t take_d;

  // Register decode
  wire hit_enable = reg_addr == TLIC_OFS_ENABLE;
  wire hit_ext = reg_addr == TLIC_OFS_EXT;
  wire hit_level = reg_addr == TLIC_OFS_LEVEL;
  wire hit_wdog = reg_addr == TLIC_OFS_WDOG;
  wire [2:0] bit_idx = reg_addr[2:0];
  wire [4:0] bit_base = reg_addr[7:3];
  wire bhit_enable = bit_base == TLIC_OFS_ENABLE[7:3];
  wire bhit_level = bit_base == TLIC_OFS_LEVEL[7:3];
  wire bhit_wdog = bit_base == TLIC_OFS_WDOG[7:3];

  // Apply a byte or a single-bit write to one register
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic bw, input logic bb,
                                     input logic [2:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    r = cur;
    if (bw) begin
      r = wd;
    end
    if (bb) begin
      r[idx] = wd[0];
    end
    return r;
  endfunction

  // Next register values; the extended register has no bit access
  assign enable_d = upd(enable_q, reg_wr && hit_enable, bit_wr && bhit_enable, bit_idx, reg_wdata); // [R9]
  assign level_sel_d = upd(level_sel_q, reg_wr && hit_level, bit_wr && bhit_level, bit_idx, reg_wdata); // [R9]
  assign wdog_d = upd(wdog_ctrl_q, reg_wr && hit_wdog, bit_wr && bhit_wdog, bit_idx, reg_wdata); // [R13]
  assign ext_d = (reg_wr && hit_ext) ? ((reg_wdata & ~TLIC_EXT_RSVD_MASK) | TLIC_EXT_RSVD_MASK) : ext_q; // [R8]

  // Read mux; unmapped addresses read zero
  wire [7:0] byte_rd = hit_enable ? enable_q : hit_ext ? ext_q : hit_level ? level_sel_q :
                       hit_wdog ? wdog_ctrl_q : 8'h00;
  wire bit_val = bhit_enable ? enable_q[bit_idx] : bhit_level ? level_sel_q[bit_idx] :
                 bhit_wdog ? wdog_ctrl_q[bit_idx] : 1'b0;
  assign rdata_d = reg_rd ? byte_rd : bit_rd ? {7'h00, bit_val} : 8'h00;

  // Per-slot enable, gated by the master enable
  wire global_irq_gate = enable_q[TLIC_B_GLOBAL_IRQ_GATE];
  wire [TLIC_NSRC-1:0] src_on;
  assign src_on[TLIC_S_SUPPLY] = ext_q[TLIC_B_SUPPLY_IRQ_ON]; // [R7]
  assign src_on[TLIC_S_CLOCK] = ext_q[TLIC_B_CLOCK_INTERVAL_IRQ_ON]; // [R7]
  assign src_on[TLIC_S_METERING] = ext_q[TLIC_B_METERING_IRQ_ON]; // [R7]
  assign src_on[TLIC_S_WDOG] = wdog_ctrl_q[TLIC_B_WDOG_IRQ_ON];
  assign src_on[TLIC_S_THERMAL] = enable_q[TLIC_B_THERMAL_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_EXT_ZERO] = enable_q[TLIC_B_EXT_ZERO_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_TIMER_ZERO] = enable_q[TLIC_B_TIMER_ZERO_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_EXT_ONE] = enable_q[TLIC_B_EXT_ONE_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_TIMER_ONE] = enable_q[TLIC_B_TIMER_ONE_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_SERIAL_BUS] = ext_q[TLIC_B_SERIAL_BUS_IRQ_ON]; // [R7]
  assign src_on[TLIC_S_UART] = enable_q[TLIC_B_UART_IRQ_ON]; // [R4]
  assign src_on[TLIC_S_TIMER_TWO] = enable_q[TLIC_B_TIMER_TWO_IRQ_ON]; // [R4]
  wire [TLIC_NSRC-1:0] elig = global_irq_gate ? (src_req & src_on) : '0; // [R3]

  // Level of each slot; only the supply slot can reach the top level
  wire [2*TLIC_NSRC-1:0] lvls;
  assign lvls[2*TLIC_S_SUPPLY +: 2] = TLIC_LVL_TOP; // [R1]
  assign lvls[2*TLIC_S_CLOCK +: 2] = {1'b0, ext_q[TLIC_B_CLOCK_IRQ_LEVEL]}; // [R6]
  assign lvls[2*TLIC_S_METERING +: 2] = {1'b0, level_sel_q[TLIC_B_METERING_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_WDOG +: 2] = TLIC_LVL_LOW;
  assign lvls[2*TLIC_S_THERMAL +: 2] = {1'b0, level_sel_q[TLIC_B_THERMAL_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_EXT_ZERO +: 2] = {1'b0, level_sel_q[TLIC_B_EXT_ZERO_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_TIMER_ZERO +: 2] = {1'b0, level_sel_q[TLIC_B_TIMER_ZERO_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_EXT_ONE +: 2] = {1'b0, level_sel_q[TLIC_B_EXT_ONE_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_TIMER_ONE +: 2] = {1'b0, level_sel_q[TLIC_B_TIMER_ONE_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_SERIAL_BUS +: 2] = {1'b0, ext_q[TLIC_B_SERIAL_BUS_LEVEL]}; // [R6]
  assign lvls[2*TLIC_S_UART +: 2] = {1'b0, level_sel_q[TLIC_B_UART_LEVEL]}; // [R5]
  assign lvls[2*TLIC_S_TIMER_TWO +: 2] = {1'b0, level_sel_q[TLIC_B_TIMER_TWO_LEVEL]}; // [R5]

  // Arbitration across levels and slots
  logic cand_found;
  logic [3:0] cand_src;
  logic [1:0] cand_level;
  tlic_poll u_poll (
    .elig(elig),
    .lvls(lvls),
    .found(cand_found),
    .src(cand_src),
    .level(cand_level)
  ); // [R10] [R11] [R12] [R14]

  // Nesting state; an accepted level is marked in service on the same edge
  logic [1:0] floor;
  tlic_nest u_nest (
    .clk_sys(clk_sys),
    .reset(reset),
    .take(take_d.valid),
    .take_level(take_d.level),
    .ret(core_ret),
    .active_q(in_service_q),
    .floor(floor)
  ); // [R17]

  // Accept only above the level in service; returns take precedence for one cycle
  wire accept = cand_found && ({1'b0, cand_level} + 3'h1 > {1'b0, floor}) && !core_ret; // [R2] [R14] [R15]
  assign take_d.valid = accept;
  assign take_d.src = cand_src;
  assign take_d.level = cand_level;
  assign take_d.vector = tlic_vector(cand_src); // [R16]

  // Registers and registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enable_q <= TLIC_RST_ENABLE;
      ext_q <= TLIC_RST_EXT;
      level_sel_q <= TLIC_RST_LEVEL;
      wdog_ctrl_q <= TLIC_RST_WDOG;
      reg_rdata_q <= 8'h00;
      take_q <= '0;
    end else begin
      enable_q <= enable_d;
      ext_q <= ext_d;
      level_sel_q <= level_sel_d;
      wdog_ctrl_q <= wdog_d;
      reg_rdata_q <= rdata_d;
      take_q <= take_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // An earlier eligible slot at the same level as the winner
  function automatic logic earlier_same(input logic [TLIC_NSRC-1:0] e, input logic [2*TLIC_NSRC-1:0] l,
                                        input logic [3:0] s, input logic [1:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < TLIC_NSRC; i++) begin
      if (4'(i) < s && e[i] && l[2*i +: 2] == v) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction
  wire poll_slip = cand_found && earlier_same(elig, lvls, cand_src, cand_level);

  // Some eligible slot sits above the low level, judged from the level map, not the arbiter
  function automatic logic any_raised(input logic [TLIC_NSRC-1:0] e, input logic [2*TLIC_NSRC-1:0] l);
    logic r;
    r = 1'b0;
    for (int i = 0; i < TLIC_NSRC; i++) begin
      if (e[i] && l[2*i +: 2] != TLIC_LVL_LOW) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction
  wire high_waiting = any_raised(elig, lvls);

  sequence seq_supply_pending;
    elig[TLIC_S_SUPPLY] && !in_service_q[2] && !core_ret;
  endsequence
  sequence seq_supply_taken;
    take_q.valid && take_q.src == TLIC_S_SUPPLY && take_q.level == TLIC_LVL_TOP;
  endsequence

  a_supply_preempt: assert property (seq_supply_pending |=> seq_supply_taken) // [R2]
    else $error("supply request not taken in the next cycle");
  a_supply_top: assert property (take_q.valid && take_q.level == TLIC_LVL_TOP |-> take_q.src == TLIC_S_SUPPLY) // [R1]
    else $error("top level taken by a source other than supply");
  a_master_gate: assert property (take_q.valid |-> $past(enable_q[TLIC_B_GLOBAL_IRQ_GATE])) // [R3]
    else $error("interrupt taken with master enable clear");
  a_ext_zero_enable: assert property (take_q.valid && take_q.src == TLIC_S_EXT_ZERO |-> $past(enable_q[0])) // [R4]
    else $error("ext zero taken while disabled");
  a_metering_level: assert property (take_q.valid && take_q.src == TLIC_S_METERING |->
                                     take_q.level == {1'b0, $past(level_sel_q[7])}) // [R5]
    else $error("metering level does not follow its select bit");
  a_clock_level: assert property (take_q.valid && take_q.src == TLIC_S_CLOCK |->
                                  take_q.level == {1'b0, $past(ext_q[6])} && $past(ext_q[2])) // [R6] [R7]
    else $error("clock interval level or enable mismatch");
  a_ext_reserved: assert property ((ext_q & TLIC_EXT_RSVD_MASK) == TLIC_EXT_RSVD_MASK) // [R8]
    else $error("reserved bits of extended register changed");
  a_poll_order: assert property (!poll_slip) // [R10] [R11] [R12]
    else $error("later slot won over an earlier one of the same level");
  a_same_level: assert property (take_q.valid |-> $past(floor) <= {1'b0, take_q.level}) // [R15]
    else $error("routine pre-empted at its own level");
  a_high_first: assert property (take_q.valid && take_q.level == TLIC_LVL_LOW |-> !$past(high_waiting)) // [R14]
    else $error("low request taken while a higher one waited");
  a_vector_load: assert property (take_q.valid |-> take_q.vector[2:0] == 3'h3 &&
                                  (take_q.src != TLIC_S_SUPPLY || take_q.vector == 16'h0043)) // [R16]
    else $error("wrong vector loaded");
  a_reti_unwind: assert property (core_ret && floor != 2'h0 |=> floor < $past(floor)) // [R17]
    else $error("return did not unwind the top level in service");
  a_reset_values: assert property ($past(reset) |-> enable_q == 8'h00 && level_sel_q == 8'h00 &&
                                   wdog_ctrl_q == 8'h10 && ext_q == 8'hA0) // [R9] [R13]
    else $error("register reset value wrong");

endmodule // tlic_ctrl

// file: core/tlic_nest.sv
// In-service tracking, one bit per level, unwound on return
module tlic_nest import tlic_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic take, // A request is accepted
  input wire logic [1:0] take_level, // Level of that request
  input wire logic ret, // Service routine returns
  output logic [2:0] active_q, // Levels in service
  output logic [1:0] floor // Highest level in service plus one, 0 if idle
);

  logic [2:0] active_d;
  logic [2:0] unwound;

  // Return clears only the topmost level in service
  assign unwound = active_q[2] ? {1'b0, active_q[1:0]} :
                   active_q[1] ? {2'b00, active_q[0]} : 3'b000;
  assign floor = active_q[2] ? 2'h3 : active_q[1] ? 2'h2 : active_q[0] ? 2'h1 : 2'h0;
  assign active_d = (ret ? unwound : active_q) | (take ? (3'b001 << take_level) : 3'b000);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_q <= 3'b000;
    end else begin
      active_q <= active_d;
    end
  end

endmodule // tlic_nest

// file: core/tlic_pkg.sv
package tlic_pkg;

  // Register offsets in the special register space
  localparam logic [7:0] TLIC_OFS_ENABLE = 8'hA8;
  localparam logic [7:0] TLIC_OFS_EXT = 8'hA9;
  localparam logic [7:0] TLIC_OFS_LEVEL = 8'hB8;
  localparam logic [7:0] TLIC_OFS_WDOG = 8'hC0;

  // Reset values
  localparam logic [7:0] TLIC_RST_ENABLE = 8'h00;
  localparam logic [7:0] TLIC_RST_EXT = 8'hA0;
  localparam logic [7:0] TLIC_RST_LEVEL = 8'h00;
  localparam logic [7:0] TLIC_RST_WDOG = 8'h10;

  // Reserved bits of the extended register hold their reset value
  localparam logic [7:0] TLIC_EXT_RSVD_MASK = 8'hA0;

  // Field positions in the enable register
  localparam int TLIC_B_GLOBAL_IRQ_GATE = 7;
  localparam int TLIC_B_THERMAL_IRQ_ON = 6;
  localparam int TLIC_B_TIMER_TWO_IRQ_ON = 5;
  localparam int TLIC_B_UART_IRQ_ON = 4;
  localparam int TLIC_B_TIMER_ONE_IRQ_ON = 3;
  localparam int TLIC_B_EXT_ONE_IRQ_ON = 2;
  localparam int TLIC_B_TIMER_ZERO_IRQ_ON = 1;
  localparam int TLIC_B_EXT_ZERO_IRQ_ON = 0;

  // Field positions in the level select register
  localparam int TLIC_B_METERING_LEVEL = 7;
  localparam int TLIC_B_THERMAL_LEVEL = 6;
  localparam int TLIC_B_TIMER_TWO_LEVEL = 5;
  localparam int TLIC_B_UART_LEVEL = 4;
  localparam int TLIC_B_TIMER_ONE_LEVEL = 3;
  localparam int TLIC_B_EXT_ONE_LEVEL = 2;
  localparam int TLIC_B_TIMER_ZERO_LEVEL = 1;
  localparam int TLIC_B_EXT_ZERO_LEVEL = 0;

  // Field positions in the extended enable/level register
  localparam int TLIC_B_CLOCK_IRQ_LEVEL = 6;
  localparam int TLIC_B_SERIAL_BUS_LEVEL = 4;
  localparam int TLIC_B_METERING_IRQ_ON = 3;
  localparam int TLIC_B_CLOCK_INTERVAL_IRQ_ON = 2;
  localparam int TLIC_B_SUPPLY_IRQ_ON = 1;
  localparam int TLIC_B_SERIAL_BUS_IRQ_ON = 0;

  // Watchdog control bit that lets the watchdog raise an interrupt
  localparam int TLIC_B_WDOG_IRQ_ON = 3;

  // Source slots, numbered in polling order (0 is polled first)
  localparam int TLIC_NSRC = 12;
  localparam logic [3:0] TLIC_S_SUPPLY = 4'h0;
  localparam logic [3:0] TLIC_S_CLOCK = 4'h1;
  localparam logic [3:0] TLIC_S_METERING = 4'h2;
  localparam logic [3:0] TLIC_S_WDOG = 4'h3;
  localparam logic [3:0] TLIC_S_THERMAL = 4'h4;
  localparam logic [3:0] TLIC_S_EXT_ZERO = 4'h5;
  localparam logic [3:0] TLIC_S_TIMER_ZERO = 4'h6;
  localparam logic [3:0] TLIC_S_EXT_ONE = 4'h7;
  localparam logic [3:0] TLIC_S_TIMER_ONE = 4'h8;
  localparam logic [3:0] TLIC_S_SERIAL_BUS = 4'h9;
  localparam logic [3:0] TLIC_S_UART = 4'hA;
  localparam logic [3:0] TLIC_S_TIMER_TWO = 4'hB;

  // Priority levels
  localparam logic [1:0] TLIC_LVL_LOW = 2'h0;
  localparam logic [1:0] TLIC_LVL_HIGH = 2'h1;
  localparam logic [1:0] TLIC_LVL_TOP = 2'h2;

  // One accepted interrupt handed to the core
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [1:0] level;
    logic [15:0] vector;
  } tlic_take_t;

  // Vector address of each polling slot
  function automatic logic [15:0] tlic_vector(input logic [3:0] src);
    case (src)
      TLIC_S_EXT_ZERO: tlic_vector = 16'h0003;
      TLIC_S_TIMER_ZERO: tlic_vector = 16'h000B;
      TLIC_S_EXT_ONE: tlic_vector = 16'h0013;
      TLIC_S_TIMER_ONE: tlic_vector = 16'h001B;
      TLIC_S_UART: tlic_vector = 16'h0023;
      TLIC_S_TIMER_TWO: tlic_vector = 16'h002B;
      TLIC_S_THERMAL: tlic_vector = 16'h0033;
      TLIC_S_SERIAL_BUS: tlic_vector = 16'h003B;
      TLIC_S_SUPPLY: tlic_vector = 16'h0043;
      TLIC_S_METERING: tlic_vector = 16'h004B;
      TLIC_S_CLOCK: tlic_vector = 16'h0053;
      default: tlic_vector = 16'h005B;
    endcase
  endfunction

endpackage

// file: core/tlic_poll.sv
// Fixed polling arbiter: lowest slot wins at the highest level present
module tlic_poll import tlic_pkg::*; (
  input wire logic [TLIC_NSRC-1:0] elig, // Enabled, pending requests
  input wire logic [2*TLIC_NSRC-1:0] lvls, // Two-bit level per slot
  output logic found, // Some request is eligible
  output logic [3:0] src, // Winning slot
  output logic [1:0] level // Level of the winner
);

  // Scan from the last slot down so the earliest slot of a level overwrites
  always_comb begin
    found = 1'b0;
    src = 4'h0;
    level = TLIC_LVL_LOW;
    for (int i = TLIC_NSRC - 1; i >= 0; i--) begin
      if (elig[i] && (!found || lvls[2*i +: 2] >= level)) begin
        found = 1'b1;
        src = 4'(i);
        level = lvls[2*i +: 2];
      end
    end
  end

endmodule // tlic_poll

// file: verification/tb_three_level_interrupt_controller.sv
`define TLIC_CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); \
  end \
end
module tb_three_level_interrupt_controller import tlic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bit_wr = 1'b0;
  logic bit_rd = 1'b0;
  logic [TLIC_NSRC-1:0] raise = '0;
  logic ret_go = 1'b0;
  logic [7:0] reg_rdata_q, wdog_ctrl_q;
  logic [TLIC_NSRC-1:0] src_req;
  logic core_ret;
  tlic_take_t take_q;
  logic [2:0] in_service_q;
  int n_fail = 0;
  int comparisons = 0;
  // Vector of each slot in polling order, and the enable bit to slot mapping
  logic [15:0] vtab [12] = '{16'h0043, 16'h0053, 16'h004B, 16'h005B, 16'h0033, 16'h0003,
    16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B};
  logic [7:0] m_a8 [11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] m_a9 [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h04, 8'h08};
  logic [3:0] m_slot [11] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB, 4'h4, 4'h9, 4'h0, 4'h1, 4'h2};

  always #5 clk_sys = ~clk_sys;

  tlic_ctrl i_tlic_ctrl (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .bit_wr(bit_wr), .bit_rd(bit_rd), .reg_rdata_q(reg_rdata_q),
    .src_req(src_req), .core_ret(core_ret), .take_q(take_q), .in_service_q(in_service_q),
    .wdog_ctrl_q(wdog_ctrl_q));
  tlic_src_model i_tlic_src_model (.clk_sys(clk_sys), .reset(reset), .raise(raise), .ret_go(ret_go),
    .take_q(take_q), .src_req(src_req), .core_ret(core_ret));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Byte or bit write, strobe held for exactly one cycle
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= ~b;
    bit_wr <= b;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    bit_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= ~b;
    bit_rd <= b;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    bit_rd <= 1'b0;
    #1;
    `TLIC_CHK(reg_rdata_q, exp)
  endtask

  task automatic req(input logic [TLIC_NSRC-1:0] m);
    @(posedge clk_sys);
    raise <= m;
    @(posedge clk_sys);
    raise <= '0;
  endtask

  // Return pulse reaches the controller one cycle after ret_go
  task automatic do_ret(input logic [2:0] exp_svc);
    @(posedge clk_sys);
    ret_go <= 1'b1;
    @(posedge clk_sys);
    ret_go <= 1'b0;
    @(posedge clk_sys);
    #1;
    `TLIC_CHK(in_service_q, exp_svc)
  endtask

  task automatic no_take(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      `TLIC_CHK(take_q.valid, 1'b0)
    end
  endtask

  // Bounded wait for an acceptance, then check slot, level and vector
  task automatic wait_take(input logic [3:0] s, input logic [1:0] lv);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if (take_q.valid === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      $display("[FAIL] %0t no acceptance", $time);
      summarize();
    end else begin
      `TLIC_CHK(take_q.src, s)
      `TLIC_CHK(take_q.level, lv)
      `TLIC_CHK(take_q.vector, vtab[s])
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(0, 8'hA8, 8'h00);
    rd(0, 8'hB8, 8'h00);
    rd(0, 8'hA9, 8'hA0);
    rd(0, 8'hC0, 8'h10);
    rd(0, 8'h90, 8'h00);
    `TLIC_CHK(wdog_ctrl_q, 8'h10)
    $display("test reset values done");
    wr(0, 8'hA9, 8'hFF);
    rd(0, 8'hA9, 8'hFF);
    wr(0, 8'hA9, 8'h00);
    rd(0, 8'hA9, 8'hA0);
    wr(1, 8'hA9, 8'h01);
    rd(0, 8'hA8, 8'h02);
    rd(1, 8'hA9, 8'h01);
    wr(1, 8'hBF, 8'h01);
    rd(0, 8'hB8, 8'h80);
    wr(1, 8'hC3, 8'h01);
    rd(0, 8'hC0, 8'h18);
    wr(1, 8'h90, 8'h01);
    rd(1, 8'h90, 8'h00);
    $display("test register access done");
    // Everything enabled but the master gate: nothing may be accepted
    wr(0, 8'hB8, 8'h00);
    wr(0, 8'hA8, 8'h7F);
    wr(0, 8'hA9, 8'h0F);
    req('1);
    no_take(6);
    wr(1, 8'hC3, 8'h00);
    wr(0, 8'hA9, 8'h00);
    wr(0, 8'hA8, 8'h00);
    // One enable bit at a time with all untaken sources pending picks exactly its source
    // Gate off while the enables change, so the acceptance follows the last write
    for (int k = 0; k < 11; k++) begin
      wr(0, 8'hA8, 8'h00);
      wr(0, 8'hA9, m_a9[k]);
      wr(0, 8'hA8, 8'h80 | m_a8[k]);
      wait_take(m_slot[k], (m_slot[k] == TLIC_S_SUPPLY) ? TLIC_LVL_TOP : TLIC_LVL_LOW);
      do_ret(3'h0);
    end
    wr(1, 8'hC3, 8'h01);
    wait_take(TLIC_S_WDOG, TLIC_LVL_LOW);
    do_ret(3'h0);
    $display("test enable mapping done");
    // All pending at once: taken strictly in polling order, one per return
    wr(0, 8'hA8, 8'h00);
    req('1);
    wr(0, 8'hA9, 8'h0F);
    wr(0, 8'hA8, 8'hFF);
    for (int k = 0; k < 12; k++) begin
      wait_take(4'(k), (k == 0) ? TLIC_LVL_TOP : TLIC_LVL_LOW);
      `TLIC_CHK(in_service_q, (k == 0) ? 3'h4 : 3'h1)
      no_take(3);
      do_ret(3'h0);
    end
    $display("test polling order done");
    // Nesting over three levels
    wr(0, 8'hB8, 8'h20);
    req(12'h820);
    wait_take(TLIC_S_TIMER_TWO, TLIC_LVL_HIGH);
    req(12'h001);
    wait_take(TLIC_S_SUPPLY, TLIC_LVL_TOP);
    `TLIC_CHK(in_service_q, 3'h6)
    req(12'h040);
    no_take(4);
    do_ret(3'h2);
    no_take(3);
    do_ret(3'h0);
    wait_take(TLIC_S_EXT_ZERO, TLIC_LVL_LOW);
    no_take(3);
    wr(1, 8'hB9, 8'h01);
    wait_take(TLIC_S_TIMER_ZERO, TLIC_LVL_HIGH);
    `TLIC_CHK(in_service_q, 3'h3)
    do_ret(3'h1);
    do_ret(3'h0);
    wr(0, 8'hB8, 8'h80);
    wr(0, 8'hA9, 8'h5F);
    req(12'h206);
    wait_take(TLIC_S_CLOCK, TLIC_LVL_HIGH);
    do_ret(3'h0);
    wait_take(TLIC_S_METERING, TLIC_LVL_HIGH);
    do_ret(3'h0);
    wait_take(TLIC_S_SERIAL_BUS, TLIC_LVL_HIGH);
    do_ret(3'h0);
    $display("test nesting done");
    summarize();
  end
endmodule // tb_three_level_interrupt_controller

// file: verification/tlic_src_model.sv
// Peripheral sources and core return path facing the controller
module tlic_src_model import tlic_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [TLIC_NSRC-1:0] raise, // One-cycle raise per slot
  input wire logic ret_go, // Core asked to end its routine
  input wire tlic_take_t take_q, // Accepted interrupt
  output logic [TLIC_NSRC-1:0] src_req, // Pending request levels
  output logic core_ret // Return pulse to the controller
);
  logic [TLIC_NSRC-1:0] drop;
  // No flag clearing in the controller, so a source drops its own request once taken
  assign drop = take_q.valid ? (TLIC_NSRC'(1) << take_q.src) : '0;
  // Requests stay pending until taken, which keeps losers of an arbitration waiting
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src_req <= '0;
      core_ret <= 1'b0;
    end else begin
      src_req <= (src_req | raise) & ~drop;
      core_ret <= ret_go;
    end
  end
endmodule // tlic_src_model
